/* hw/scm_consts.vh */
// constants for the servo control mode switch block
`ifndef SCM_CONSTS_VH
`define SCM_CONSTS_VH

// register byte offsets
`define SCM_OFF_CTRL 8'h00
`define SCM_OFF_ACCEL 8'h04
`define SCM_OFF_DECEL 8'h08
`define SCM_OFF_TOL 8'h0C
`define SCM_OFF_SPEED1 8'h10
`define SCM_OFF_SPEED7 8'h28
`define SCM_OFF_STATUS 8'h30
`define SCM_OFF_SPEEDREF 8'h34
`define SCM_OFF_LIMIT 8'h38

// control register fields
`define SCM_CTRL_MODE_LSB 0
`define SCM_CTRL_MODE_MSB 3
`define SCM_CTRL_ABS_BIT 4
`define SCM_CTRL_SEL2_EN_BIT 5

// status register fields
`define SCM_ST_POS_BIT 0
`define SCM_ST_SPD_BIT 1
`define SCM_ST_TRQ_BIT 2
`define SCM_ST_LIMITING_BIT 3
`define SCM_ST_REACHED_BIT 4
`define SCM_ST_REFUSED_BIT 5
`define SCM_ST_ZERO_BIT 6

// control mode parameter values
`define SCM_MODE_POSITION 4'h0
`define SCM_MODE_POS_SPD 4'h1
`define SCM_MODE_SPEED 4'h2
`define SCM_MODE_SPD_TRQ 4'h3
`define SCM_MODE_TORQUE 4'h4

// reset values
`define SCM_RST_CTRL 32'h00000000
`define SCM_RST_ACCEL 16'h0010
`define SCM_RST_DECEL 16'h0010
`define SCM_RST_TOL 16'h0020
`define SCM_RST_SPEED 16'h0000

`endif

/* hw/scm_sync.v */
// three-stage synchroniser with agreement filter for contact inputs
`timescale 1ns/1ps
module scm_sync #(
  parameter WIDTH = 9
) (
  input wire mclk,
  input wire nrst,
  input wire [WIDTH-1:0] raw_in,
  output wire [WIDTH-1:0] clean_out
);
  reg [WIDTH-1:0] ff1_reg;
  reg [WIDTH-1:0] ff2_reg;
  reg [WIDTH-1:0] ff3_reg;
  reg [WIDTH-1:0] clean_reg;
  wire [WIDTH-1:0] agree;
  wire [WIDTH-1:0] clean_next;

  // a bit follows only once stages two and three agree
  assign agree = ~(ff2_reg ^ ff3_reg);
  assign clean_next = (agree & ff3_reg) | (~agree & clean_reg);
  assign clean_out = clean_reg;

  always @(posedge mclk) begin
    if (!nrst) begin
      ff1_reg <= {WIDTH{1'b0}};
      ff2_reg <= {WIDTH{1'b0}};
      ff3_reg <= {WIDTH{1'b0}};
      clean_reg <= {WIDTH{1'b0}};
    end else begin
      ff1_reg <= raw_in;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      clean_reg <= clean_next;
    end
  end
endmodule // scm_sync

/* hw/scm_ramp.v */
// speed reference ramp with separate acceleration and deceleration steps
`timescale 1ns/1ps
module scm_ramp #(
  parameter W = 16
) (
  input wire mclk,
  input wire nrst,
  input wire signed [W-1:0] target_in,
  input wire [W-1:0] accel_step,
  input wire [W-1:0] decel_step,
  output wire signed [W-1:0] ref_out
);
  reg signed [W-1:0] ref_reg;
  reg signed [W-1:0] ref_next;
  reg signed [W:0] diff;
  reg [W-1:0] step;
  reg away;

  assign ref_out = ref_reg;

  always @* begin
    diff = {target_in[W-1], target_in} - {ref_reg[W-1], ref_reg};
    // moving away from zero accelerates, toward zero decelerates
    away = diff[W] ? (ref_reg[W-1] || ref_reg == {W{1'b0}}) :
      !ref_reg[W-1];
    step = away ? accel_step : decel_step;
    ref_next = ref_reg;
    if (!diff[W] && diff > $signed({2'b00, step[W-2:0]})) begin
      ref_next = ref_reg + $signed({1'b0, step[W-2:0]});
    end else if (diff[W] && -diff > $signed({2'b00, step[W-2:0]})) begin
      ref_next = ref_reg - $signed({1'b0, step[W-2:0]});
    end else begin
      ref_next = target_in;
    end
  end

  always @(posedge mclk) begin
    if (!nrst) begin
      ref_reg <= {W{1'b0}};
    end else begin
      ref_reg <= ref_next;
    end
  end
endmodule // scm_ramp

/* hw/scm_top.v */
// servo control mode switch: mode selection, speed source and limit logic
//
// Function
// RULE1: limiting_speed_flag rises when motor speed reaches the active speed limit, internal or analog.
// RULE2: mode switching in position/speed change mode is refused while absolute position detection is on.
// RULE3: in position/speed change mode the mode-change input off selects position, on selects speed.
// RULE4: a position/speed mode change is made only while zero_speed_flag holds; abs_en set forces speed control back to position at any speed.
// RULE5: the droop pulse count is cleared on a change from position to speed control.
// RULE6: a mode-change edge seen while not at zero speed is dropped and never applied later.
// RULE7: in speed control the target is an internal or analog command, signed by the start inputs.
// RULE8: with two select bits, code 0 picks the analog command and 1 to 3 pick internal commands.
// RULE9: with the third select bit enabled, code 0 is analog and codes 1 to 7 pick internal commands.
// RULE10: speed selection changes are ramped through the acceleration and deceleration steps.
// RULE11: mode parameter 3 gives speed/torque change mode, mode-change off speed, on torque.
// RULE12: in speed/torque change mode the mode follows the input at any moment.
// RULE13: with both starts off in speed control the motor ramps to stop by the deceleration step.
// RULE14: in torque control of speed/torque mode the limit is internal speed one or the analog limit.
// RULE15: there select bit zero picks the analog limit when 0 and internal speed one when 1.
// RULE16: limit direction follows the rotation selects, analog negative polarity inverting it.
// RULE17: contact inputs are synchronised and mode-change edges gated by zero speed in the same cycle.
`timescale 1ns/1ps
`include "scm_consts.vh"
module scm_top #(
  parameter W = 16
) (
  input wire mclk,
  input wire nrst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire mode_change_in,
  input wire speed_select_bit0,
  input wire speed_select_bit1,
  input wire speed_select_bit2,
  input wire forward_start_in,
  input wire reverse_start_in,
  input wire forward_select_in,
  input wire reverse_select_in,
  input wire zero_speed_flag,
  input wire signed [W-1:0] motor_speed_in,
  input wire signed [W-1:0] analog_speed_cmd_in,
  input wire signed [W-1:0] analog_speed_limit_in,
  output wire position_ctrl,
  output wire speed_ctrl,
  output wire torque_ctrl,
  output wire droop_clear,
  output wire signed [W-1:0] speed_ref_out,
  output wire signed [W-1:0] speed_limit_out,
  output wire limiting_speed_flag,
  output wire speed_reached_flag,
  output wire mode_refused
);
  localparam ST_POS = 3'b001;
  localparam ST_SPD = 3'b010;
  localparam ST_TRQ = 3'b100;

  function [W-1:0] abs_val;
    input signed [W-1:0] v;
    begin
      if (!v[W-1]) begin
        abs_val = v;
      end else if (v == {1'b1, {(W-1){1'b0}}}) begin
        abs_val = {1'b0, {(W-1){1'b1}}};
      end else begin
        abs_val = -v;
      end
    end
  endfunction

  // software registers
  reg [31:0] ctrl_reg;
  reg [W-1:0] accel_reg;
  reg [W-1:0] decel_reg;
  reg [W-1:0] tol_reg;
  reg [W-1:0] int_speed_reg [1:7];
  reg [31:0] hrdata_reg;
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;
  integer i;

  // control state
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg mode_sel_prev_reg;
  reg droop_clear_reg;
  reg signed [W-1:0] limit_reg;
  reg limiting_reg;
  reg reached_reg;
  reg refused_reg;

  wire [7:0] contacts;
  wire mode_sel;
  wire sel0;
  wire sel1;
  wire sel2;
  wire st_fwd;
  wire st_rev;
  wire rs_fwd;
  wire rs_rev;
  wire [3:0] mode_param;
  wire abs_en;
  wire sel2_en;
  wire mode_sel_edge;
  wire signed [W-1:0] ramp_ref;

  scm_sync #(
    .WIDTH(8)
  ) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .raw_in({reverse_select_in, forward_select_in, reverse_start_in,
      forward_start_in, speed_select_bit2, speed_select_bit1,
      speed_select_bit0, mode_change_in}),
    .clean_out(contacts)
  ); // RULE17

  assign mode_sel = contacts[0];
  assign sel0 = contacts[1];
  assign sel1 = contacts[2];
  assign sel2 = contacts[3];
  assign st_fwd = contacts[4];
  assign st_rev = contacts[5];
  assign rs_fwd = contacts[6];
  assign rs_rev = contacts[7];
  assign mode_param = ctrl_reg[`SCM_CTRL_MODE_MSB:`SCM_CTRL_MODE_LSB];
  assign abs_en = ctrl_reg[`SCM_CTRL_ABS_BIT];
  assign sel2_en = ctrl_reg[`SCM_CTRL_SEL2_EN_BIT];
  assign mode_sel_edge = mode_sel ^ mode_sel_prev_reg; // RULE17

  // mode selection
  always @* begin
    state_next = state_reg;
    if (mode_param == `SCM_MODE_POS_SPD) begin
      if (abs_en) begin
        state_next = ST_POS; // RULE2
      end else if (state_reg == ST_TRQ) begin
        state_next = ST_POS;
      end else if (mode_sel_edge && zero_speed_flag) begin // RULE4 RULE6
        state_next = mode_sel ? ST_SPD : ST_POS; // RULE3
      end
    end else if (mode_param == `SCM_MODE_SPD_TRQ) begin
      state_next = mode_sel ? ST_TRQ : ST_SPD; // RULE11 RULE12
    end else if (mode_param == `SCM_MODE_SPEED) begin
      state_next = ST_SPD;
    end else if (mode_param == `SCM_MODE_TORQUE) begin
      state_next = ST_TRQ;
    end else begin
      state_next = ST_POS;
    end
  end

  // speed source and limit selection
  reg [2:0] cmd_idx;
  reg [2:0] lim_idx;
  reg signed [W-1:0] cmd_sel;
  reg signed [W-1:0] target;
  reg [W-1:0] lim_mag;
  reg lim_neg;
  reg lim_valid;
  reg signed [W-1:0] limit_next;
  reg [W:0] err;
  reg [W-1:0] err_mag;

  always @* begin
    cmd_idx = sel2_en ? {sel2, sel1, sel0} : {1'b0, sel1, sel0}; // RULE8 RULE9
    if (mode_param == `SCM_MODE_SPD_TRQ) begin
      lim_idx = {2'b00, sel0}; // RULE14 RULE15
    end else begin
      lim_idx = cmd_idx;
    end
    if (cmd_idx == 3'h0) begin
      cmd_sel = analog_speed_cmd_in;
    end else begin
      cmd_sel = int_speed_reg[cmd_idx];
    end
    target = {W{1'b0}};
    if (state_reg == ST_SPD) begin
      if (st_fwd && !st_rev) begin
        target = cmd_sel; // RULE7
      end else if (st_rev && !st_fwd) begin
        target = -cmd_sel; // RULE7
      end else begin
        target = {W{1'b0}}; // RULE13
      end
    end
    if (lim_idx == 3'h0) begin
      lim_mag = abs_val(analog_speed_limit_in);
      lim_neg = rs_rev ^ analog_speed_limit_in[W-1]; // RULE16
    end else begin
      lim_mag = int_speed_reg[lim_idx];
      lim_neg = rs_rev; // RULE16
    end
    lim_valid = rs_fwd ^ rs_rev;
    limit_next = {W{1'b0}};
    if (state_reg == ST_TRQ && lim_valid) begin
      limit_next = lim_neg ? -$signed(lim_mag) : $signed(lim_mag);
    end
    err = {motor_speed_in[W-1], motor_speed_in} - {target[W-1], target};
    err_mag = err[W] ? -err[W-1:0] : err[W-1:0];
  end

  scm_ramp #(
    .W(W)
  ) u_ramp (
    .mclk(mclk),
    .nrst(nrst),
    .target_in(target),
    .accel_step(accel_reg),
    .decel_step(decel_reg),
    .ref_out(ramp_ref)
  ); // RULE10 RULE13

  always @(posedge mclk) begin
    if (!nrst) begin
      state_reg <= ST_POS;
      mode_sel_prev_reg <= 1'b0;
      droop_clear_reg <= 1'b0;
      limit_reg <= {W{1'b0}};
      limiting_reg <= 1'b0;
      reached_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_sel_prev_reg <= mode_sel;
      droop_clear_reg <= (state_reg == ST_POS) && (state_next == ST_SPD); // RULE5
      limit_reg <= limit_next;
      limiting_reg <= (state_reg == ST_TRQ) && lim_valid &&
        (abs_val(motor_speed_in) >= lim_mag); // RULE1
      reached_reg <= (state_reg == ST_SPD) && (err_mag <= tol_reg);
      refused_reg <= (mode_param == `SCM_MODE_POS_SPD) && abs_en; // RULE2
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  wire addr_phase;
  wire [7:0] a;
  reg [31:0] rd_mux;
  wire [31:0] status_word;

  assign addr_phase = hsel && hready && htrans[1];
  assign a = haddr[7:0];
  assign status_word = {25'h0, zero_speed_flag, refused_reg, reached_reg,
    limiting_reg, state_reg[2], state_reg[1], state_reg[0]};

  always @* begin
    rd_mux = 32'h00000000;
    if (a == `SCM_OFF_CTRL) begin
      rd_mux = ctrl_reg;
    end else if (a == `SCM_OFF_ACCEL) begin
      rd_mux = {{(32-W){1'b0}}, accel_reg};
    end else if (a == `SCM_OFF_DECEL) begin
      rd_mux = {{(32-W){1'b0}}, decel_reg};
    end else if (a == `SCM_OFF_TOL) begin
      rd_mux = {{(32-W){1'b0}}, tol_reg};
    end else if (a >= `SCM_OFF_SPEED1 && a <= `SCM_OFF_SPEED7 &&
      a[1:0] == 2'b00) begin
      rd_mux = {{(32-W){1'b0}}, int_speed_reg[a[4:2] - 3'h3]};
    end else if (a == `SCM_OFF_STATUS) begin
      rd_mux = status_word;
    end else if (a == `SCM_OFF_SPEEDREF) begin
      rd_mux = {{(32-W){1'b0}}, ramp_ref};
    end else if (a == `SCM_OFF_LIMIT) begin
      rd_mux = {{(32-W){1'b0}}, limit_reg};
    end
  end

  always @(posedge mclk) begin
    if (!nrst) begin
      ctrl_reg <= `SCM_RST_CTRL;
      accel_reg <= `SCM_RST_ACCEL;
      decel_reg <= `SCM_RST_DECEL;
      tol_reg <= `SCM_RST_TOL;
      for (i = 1; i <= 7; i = i + 1) begin
        int_speed_reg[i] <= `SCM_RST_SPEED;
      end
      hrdata_reg <= 32'h00000000;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_reg <= a;
        hrdata_reg <= hwrite ? 32'h00000000 : rd_mux;
      end
      if (wr_pend_reg) begin
        if (wr_addr_reg == `SCM_OFF_CTRL) begin
          ctrl_reg <= {26'h0, hwdata[5:0]};
        end else if (wr_addr_reg == `SCM_OFF_ACCEL) begin
          accel_reg <= hwdata[W-1:0];
        end else if (wr_addr_reg == `SCM_OFF_DECEL) begin
          decel_reg <= hwdata[W-1:0];
        end else if (wr_addr_reg == `SCM_OFF_TOL) begin
          tol_reg <= hwdata[W-1:0];
        end else if (wr_addr_reg >= `SCM_OFF_SPEED1 &&
          wr_addr_reg <= `SCM_OFF_SPEED7 && wr_addr_reg[1:0] == 2'b00) begin
          int_speed_reg[wr_addr_reg[4:2] - 3'h3] <= hwdata[W-1:0];
        end
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign position_ctrl = state_reg[0];
  assign speed_ctrl = state_reg[1];
  assign torque_ctrl = state_reg[2];
  assign droop_clear = droop_clear_reg;
  assign speed_ref_out = ramp_ref;
  assign speed_limit_out = limit_reg;
  assign limiting_speed_flag = limiting_reg;
  assign speed_reached_flag = reached_reg;
  assign mode_refused = refused_reg;
endmodule // scm_top

/* bench/scm_ctrl_model.sv */
// contact-level model of the external motion controller
`timescale 1ns/1ps
module scm_ctrl_model (
  input wire mclk,
  input wire [7:0] want,
  input wire zero_spd,
  input wire honour,
  output logic [7:0] pins
);
  initial pins = 8'h00;
  always @(posedge mclk) begin
    pins[7:1] <= want[7:1];
    // a polite controller moves the mode contact only at standstill
    if (!honour || zero_spd) begin
      pins[0] <= want[0];
    end
  end
endmodule // scm_ctrl_model

/* bench/scm_top_checker.sv */
// port assertions for the servo control mode switch
`timescale 1ns/1ps
module scm_top_checker #(
  parameter W = 16
) (
  input wire mclk,
  input wire nrst,
  input wire zero_speed_flag,
  input wire position_ctrl,
  input wire speed_ctrl,
  input wire torque_ctrl,
  input wire droop_clear,
  input wire signed [W-1:0] speed_ref_out,
  input wire signed [W-1:0] speed_limit_out,
  input wire limiting_speed_flag,
  input wire speed_reached_flag,
  input wire mode_refused
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_pos_to_spd;
    position_ctrl ##1 speed_ctrl;
  endsequence
  property p_onehot;
    $onehot({position_ctrl, speed_ctrl, torque_ctrl});
  endproperty
  property p_droop;
    s_pos_to_spd |-> droop_clear;
  endproperty
  property p_droop_cause;
    droop_clear |-> speed_ctrl && $past(position_ctrl);
  endproperty
  property p_nozero;
    position_ctrl && !zero_speed_flag |=> !speed_ctrl;
  endproperty
  property p_limzero;
    !torque_ctrl && $past(!torque_ctrl) |-> speed_limit_out == 0;
  endproperty
  property p_limflag;
    limiting_speed_flag |-> $past(torque_ctrl);
  endproperty
  property p_reached;
    speed_reached_flag |-> $past(speed_ctrl);
  endproperty
  property p_ramp;
    !speed_ctrl && $past(speed_ref_out) > 0 |->
      speed_ref_out >= 0 && speed_ref_out <= $past(speed_ref_out);
  endproperty
  property p_refuse;
    mode_refused && $past(mode_refused) |-> position_ctrl;
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("mode outputs not one-hot");
  a_droop: assert property (p_droop)
    else $error("no droop clear after position to speed");
  a_droop_cause: assert property (p_droop_cause)
    else $error("droop clear without position to speed");
  a_nozero: assert property (p_nozero)
    else $error("mode left position while not at zero speed");
  a_limzero: assert property (p_limzero)
    else $error("speed limit nonzero outside torque control");
  a_limflag: assert property (p_limflag)
    else $error("limiting flag outside torque control");
  a_reached: assert property (p_reached)
    else $error("reached flag outside speed control");
  a_ramp: assert property (p_ramp)
    else $error("reference did not fall toward zero");
  a_refuse: assert property (p_refuse)
    else $error("refused mode not held in position");
endmodule // scm_top_checker

bind scm_top scm_top_checker #(.W(W)) i_scm_top_checker (.*);

/* bench/tb_top.sv */
// self-checking bench for the servo control mode switch
`timescale 1ns/1ps
module tb_top;
  logic mclk = 0, nrst = 0, hsel = 0, hwrite = 0, rd_dp = 0;
  logic [31:0] haddr = 0, hwdata = 0, ex_v, tmp;
  logic [7:0] ad_v;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic zero_spd = 1, honour = 1;
  logic [7:0] want = 0, pins;
  logic signed [15:0] motor_speed_in = 0, analog_speed_cmd_in = 0;
  logic signed [15:0] analog_speed_limit_in = 0, lv;
  logic [15:0] spd [1:7];
  wire hreadyout, hresp, position_ctrl, speed_ctrl, torque_ctrl;
  wire droop_clear, limiting_speed_flag, speed_reached_flag, mode_refused;
  wire [31:0] hrdata;
  wire signed [15:0] speed_ref_out, speed_limit_out;
  logic [31:0] exq [$];
  logic [7:0] adq [$];
  int fails = 0, cmp_count = 0, ix;
  always #2.5 mclk = ~mclk;
  scm_ctrl_model i_scm_ctrl_model (.mclk(mclk), .want(want),
    .zero_spd(zero_spd), .honour(honour), .pins(pins));
  scm_top #(.W(16)) i_scm_top (.*, .hready(hreadyout),
    .mode_change_in(pins[0]), .speed_select_bit0(pins[1]),
    .speed_select_bit1(pins[2]), .speed_select_bit2(pins[3]),
    .forward_start_in(pins[4]), .reverse_start_in(pins[5]),
    .forward_select_in(pins[6]), .reverse_select_in(pins[7]),
    .zero_speed_flag(zero_spd));
  always @(posedge mclk) begin
    if (rd_dp && hreadyout === 1'b1) begin
      ex_v = exq.pop_front();
      ad_v = adq.pop_front();
      cmp_count++;
      if (hrdata !== ex_v) begin
        fails++;
        $display("FAIL hrdata at %h exp %h got %h", ad_v, ex_v, hrdata);
      end
      cmp_count++;
      if (hresp !== 1'b0) begin
        fails++;
        $display("FAIL hresp at %h exp 0 got %b", ad_v, hresp);
      end
    end
  end
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task wait_rdy;
    int n;
    n = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        fails++;
        tally_and_finish;
      end
      @(posedge mclk);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rd_dp <= !w;
    wait_rdy;
    rd_dp <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exq.push_back(e);
    adq.push_back(a);
    xfer(1'b0, a, 32'h0);
  endtask
  task settle;
    repeat (10) @(posedge mclk);
  endtask
  task pin(input logic [7:0] w);
    want <= w;
    settle;
  endtask
  task lim(input logic [7:0] w, input logic [15:0] al, input logic [15:0] e);
    want <= w;
    analog_speed_limit_in <= al;
    settle;
    rd(8'h38, {16'h0, e});
  endtask
  initial begin
    tmp = $urandom(32'hB150);
    tmp = $urandom;
    analog_speed_cmd_in = {2'b00, tmp[13:0]} | 16'h0100;
    tmp = $urandom;
    lv = {2'b00, tmp[13:0]} | 16'h0100;
    analog_speed_limit_in = lv;
    for (int i = 1; i < 8; i++) begin
      tmp = $urandom;
      spd[i] = {2'b00, tmp[13:0]} | 16'h0100;
    end
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h10);
    rd(8'h08, 32'h10);
    rd(8'h0C, 32'h20);
    rd(8'h30, 32'h41);
    rd(8'h3C, 32'h0);
    wr(8'h30, 32'hFF);
    rd(8'h30, 32'h41);
    wr(8'h04, 32'h7FFF);
    wr(8'h08, 32'h7FFF);
    for (int i = 1; i < 8; i++) wr(8'h0C + 8'(i * 4), {16'h0, spd[i]});
    wr(8'h00, 32'h1);
    pin(8'h11);
    rd(8'h30, 32'h42);
    for (int e = 0; e < 2; e++) begin
      for (int c = 0; c < 8; c++) begin
        wr(8'h00, {26'h0, e[0], 5'h01});
        pin({4'b0001, c[2:0], 1'b1});
        ix = e ? c : c & 3;
        rd(8'h34, {16'h0, ix == 0 ? analog_speed_cmd_in : spd[ix]});
      end
    end
    pin(8'h31);
    rd(8'h34, 32'h0);
    pin(8'h11);
    rd(8'h34, {16'h0, analog_speed_cmd_in});
    pin(8'h10);
    rd(8'h30, 32'h41);
    rd(8'h34, 32'h0);
    pin(8'h01);
    rd(8'h30, 32'h52);
    rd(8'h34, 32'h0);
    wr(8'h04, 32'h3);
    pin(8'h11);
    // target seen five edges before the read: five steps of three
    rd(8'h34, 32'hF);
    zero_spd <= 1'b0;
    honour <= 1'b0;
    pin(8'h00);
    rd(8'h30, 32'h12);
    zero_spd <= 1'b1;
    settle;
    rd(8'h30, 32'h52);
    pin(8'h01);
    pin(8'h00);
    rd(8'h30, 32'h41);
    zero_spd <= 1'b0;
    pin(8'h01);
    rd(8'h30, 32'h01);
    zero_spd <= 1'b1;
    settle;
    rd(8'h30, 32'h41);
    wr(8'h00, 32'h11);
    settle;
    rd(8'h30, 32'h61);
    wr(8'h00, 32'h3);
    zero_spd <= 1'b0;
    lim(8'h41, lv, lv);
    lim(8'h4F, lv, spd[1]);
    lim(8'h83, lv, -spd[1]);
    lim(8'h81, -lv, lv);
    lim(8'h41, -lv, -lv);
    lim(8'hC1, lv, 16'h0);
    lim(8'h41, lv, lv);
    motor_speed_in <= lv;
    settle;
    rd(8'h30, 32'h0C);
    motor_speed_in <= lv - 16'h1;
    settle;
    rd(8'h30, 32'h04);
    pin(8'h40);
    rd(8'h30, 32'h02);
    rd(8'h38, 32'h0);
    wr(8'h00, 32'h4);
    settle;
    rd(8'h30, 32'h04);
    wr(8'h00, 32'h2);
    settle;
    rd(8'h30, 32'h02);
    tally_and_finish;
  end
endmodule // tb_top
